// >>> core/pwm_ctrl_pkg.sv
// Purpose: shared constants for the pwm prescale/align/pairing control block
// Assumes: apb slave with 32-bit data, one register per aligned word
// Notes: offsets are register indices; byte address is four times the index
package pwm_ctrl_pkg;
    // ----------------------------------------
    // register indices and byte addresses
    // ----------------------------------------
    localparam logic [7:0] IDX_PRESCALE = 8'h03;
    localparam logic [7:0] IDX_CENTER = 8'h04;
    localparam logic [7:0] IDX_CONTROL = 8'h05;
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] ADDR_PRESCALE = {2'h0, IDX_PRESCALE, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CENTER = {2'h0, IDX_CENTER, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
    // ----------------------------------------
    // field layout
    // ----------------------------------------
    localparam int CLK_A_LSB = 0;
    localparam int CLK_B_LSB = 4;
    localparam int SEL_W = 3;
    localparam logic [7:0] PRESCALE_MASK = 8'h77;
    localparam int PAIR01_BIT = 4;
    localparam int PAIR23_BIT = 5;
    localparam int PAIR45_BIT = 6;
    localparam int PAIR67_BIT = 7;
    localparam int WAIT_STOP_BIT = 3;
    localparam int FREEZE_STOP_BIT = 2;
    localparam logic [7:0] CONTROL_MASK = 8'hFC;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int CHANNELS = 8;
    localparam int PRE_W = 7;
    localparam logic [PRE_W-1:0] PRE_ONE = 7'h01;
    localparam logic [PRE_W-1:0] PRE_ZERO = 7'h00;
endpackage

// >>> core/clk_div_if.sv
// Purpose: carries one prescaler tap select and its enable pulse
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ns
interface clk_div_if;
    logic [pwm_ctrl_pkg::SEL_W-1:0] sel;
    logic tick;
    modport ctrl (output sel, input tick);
    modport div (input sel, output tick);
endinterface

// >>> core/prescale_tap.sv
// Purpose: picks one power-of-two tap of the shared prescaler counter
// Assumes: counter advances only while the prescaler clock is gated on
// Notes: tick is a one-cycle enable pulse
`timescale 1ns/1ns
module prescale_tap (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // prescaler state
    input wire logic run,
    input wire logic [pwm_ctrl_pkg::PRE_W-1:0] count,
    // tap
    clk_div_if.div link
);
    logic [pwm_ctrl_pkg::PRE_W-1:0] mask;
    assign mask = pwm_ctrl_pkg::PRE_W'((pwm_ctrl_pkg::PRE_ONE << link.sel)
        - pwm_ctrl_pkg::PRE_ONE);
    // ----------------------------------------
    // tap pulse
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link.tick <= 1'b0;
        end else begin
            link.tick <= run && ((count & mask) == pwm_ctrl_pkg::PRE_ZERO);
        end
    end
endmodule

// >>> core/pwm_ctrl.sv
// Purpose: prescalers, alignment select and channel pairing for an 8-channel pwm
// Assumes: apb slave, zero wait states, bus clock clk
// Notes: registers sit in the low byte of each word
`timescale 1ns/1ns
module pwm_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pwm_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // processor modes
    input wire logic wait_mode,
    input wire logic freeze_mode,
    // channel enables from the channel logic
    input wire logic [7:0] channel_enable_bits,
    // prescaled clock enables
    output logic clk_a_tick,
    output logic clk_b_tick,
    output logic prescaler_run,
    // per-channel control
    output logic [7:0] center_mode_bits,
    output logic [3:0] pair_bits,
    output logic [7:0] effective_enable,
    output logic [7:0] high_byte_channel,
    output logic [7:0] ctrl_owner_odd
);
    logic [2:0] rst_sync_r;
    logic rst_n;
    logic [7:0] prescale_r;
    logic [7:0] center_r;
    logic [7:0] control_r;
    logic [pwm_ctrl_pkg::PRE_W-1:0] pre_cnt_r;
    logic run_nxt;
    logic [3:0] pair_nxt;
    logic [7:0] pair_even;
    logic [7:0] pair_odd;
    logic wr_en;
    logic rd_en;
    logic hit;
    logic [7:0] rd_byte;
    clk_div_if link_a ();
    clk_div_if link_b ();

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_r <= 3'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[1:0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    always_comb begin
        hit = 1'b1;
        rd_byte = pwm_ctrl_pkg::RESET_BYTE;
        unique case (paddr)
            pwm_ctrl_pkg::ADDR_PRESCALE: begin
                rd_byte = prescale_r;
            end
            pwm_ctrl_pkg::ADDR_CENTER: begin
                rd_byte = center_r;
            end
            pwm_ctrl_pkg::ADDR_CONTROL: begin
                rd_byte = control_r;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    // writes anytime, unused bits dropped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_r <= pwm_ctrl_pkg::RESET_BYTE;
        end else if (wr_en && paddr == pwm_ctrl_pkg::ADDR_PRESCALE) begin
            prescale_r <= pwdata[7:0] & pwm_ctrl_pkg::PRESCALE_MASK;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            center_r <= pwm_ctrl_pkg::RESET_BYTE;
        end else if (wr_en && paddr == pwm_ctrl_pkg::ADDR_CENTER) begin
            center_r <= pwdata[7:0];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_r <= pwm_ctrl_pkg::RESET_BYTE;
        end else if (wr_en && paddr == pwm_ctrl_pkg::ADDR_CONTROL) begin
            control_r <= pwdata[7:0] & pwm_ctrl_pkg::CONTROL_MASK;
        end
    end

    // ----------------------------------------
    // apb answer
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (rd_en) begin
                prdata <= {24'h0, rd_byte};
            end
        end
    end

    // ----------------------------------------
    // prescaler input gate and counter
    // ----------------------------------------
    // gate on wait or freeze
    assign run_nxt = !(control_r[pwm_ctrl_pkg::WAIT_STOP_BIT] && wait_mode)
        && !(control_r[pwm_ctrl_pkg::FREEZE_STOP_BIT] && freeze_mode);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_r <= pwm_ctrl_pkg::PRE_ZERO;
        end else if (run_nxt) begin
            pre_cnt_r <= pre_cnt_r + pwm_ctrl_pkg::PRE_ONE;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescaler_run <= 1'b0;
        end else begin
            prescaler_run <= run_nxt;
        end
    end

    // ----------------------------------------
    // clock A and clock B taps
    // ----------------------------------------
    // clock A select
    assign link_a.sel = prescale_r[pwm_ctrl_pkg::CLK_A_LSB +: pwm_ctrl_pkg::SEL_W];
    assign link_b.sel = prescale_r[pwm_ctrl_pkg::CLK_B_LSB +: pwm_ctrl_pkg::SEL_W];
    prescale_tap tap_a (
        .clk(clk),
        .rst_n(rst_n),
        .run(run_nxt),
        .count(pre_cnt_r),
        .link(link_a.div)
    );
    prescale_tap tap_b (
        .clk(clk),
        .rst_n(rst_n),
        .run(run_nxt),
        .count(pre_cnt_r),
        .link(link_b.div)
    );
    assign clk_a_tick = link_a.tick;
    assign clk_b_tick = link_b.tick;

    // ----------------------------------------
    // pairing and channel control
    // ----------------------------------------
    // pair bits 7..4
    assign pair_nxt = {control_r[pwm_ctrl_pkg::PAIR67_BIT], control_r[pwm_ctrl_pkg::PAIR45_BIT],
        control_r[pwm_ctrl_pkg::PAIR23_BIT], control_r[pwm_ctrl_pkg::PAIR01_BIT]};
    always_comb begin
        pair_even = 8'h00;
        pair_odd = 8'h00;
        for (int p = 0; p < 4; p++) begin
            pair_even[2 * p] = pair_nxt[p];
            pair_odd[2 * p + 1] = pair_nxt[p];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pair_bits <= 4'h0;
            center_mode_bits <= 8'h00;
            effective_enable <= 8'h00;
            high_byte_channel <= 8'h00;
            ctrl_owner_odd <= 8'h00;
        end else begin
            pair_bits <= pair_nxt;
            center_mode_bits <= center_r;
            effective_enable <= channel_enable_bits & ~pair_even;
            high_byte_channel <= pair_even;
            ctrl_owner_odd <= pair_odd;
        end
    end
endmodule

// >>> verif/pwm_ctrl_sva.sv
// Purpose: port assertions for pwm_ctrl
// Assumes: zero wait apb slave
// Notes: bound to pwm_ctrl
`timescale 1ns/1ns
module pwm_ctrl_sva (
    // clock, reset, apb
    input wire logic clk, resetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    // modes and channels
    input wire logic wait_mode, freeze_mode, clk_a_tick, clk_b_tick, prescaler_run,
    input wire logic [3:0] pair_bits,
    input wire logic [7:0] channel_enable_bits, center_mode_bits, effective_enable,
    input wire logic [7:0] high_byte_channel, ctrl_owner_odd
);
    logic [7:0] even_mask;
    assign even_mask = {1'h0, pair_bits[3], 1'h0, pair_bits[2],
        1'h0, pair_bits[1], 1'h0, pair_bits[0]};
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence s_acc(w, a);
        pready && pwrite == w && paddr == a;
    endsequence
    a_ack_next: assert property (psel && !penable |=> pready)
        else $error("no ready");
    a_err_map: assert property (pready
        |-> pslverr != (paddr inside {12'h00C, 12'h010, 12'h014})) else $error("bad slverr");
    a_pre_rsvd: assert property (s_acc(1'h0, 12'h00C)
        |-> (prdata & 32'hFFFFFF88) == 32'h0) else $error("reserved set");
    a_center_wr: assert property (s_acc(1'h1, 12'h010)
        |-> ##2 center_mode_bits == $past(pwdata[7:0], 2)) else $error("center stale");
    a_even_off: assert property ($stable(pair_bits) && $stable(channel_enable_bits)
        && $past(resetn, 3)
        |-> effective_enable == (channel_enable_bits & ~even_mask)) else $error("even on");
    a_byte_role: assert property ($stable(pair_bits)
        |-> high_byte_channel == even_mask && ctrl_owner_odd == {even_mask[6:0], 1'h0})
        else $error("pair roles");
    a_run_free: assert property (!wait_mode && !freeze_mode && !$past(wait_mode)
        && !$past(freeze_mode) && $past(resetn, 3) |-> prescaler_run) else $error("stopped");
    a_tick_stop: assert property (!prescaler_run && !$past(prescaler_run)
        |-> !clk_a_tick && !clk_b_tick) else $error("tick when off");
endmodule
bind pwm_ctrl pwm_ctrl_sva u_sva (.*);

// >>> verif/tb_pwm_ctrl.sv
// Purpose: self-checking bench for pwm_ctrl
// Assumes: zero wait apb slave, 20 MHz clock
// Notes: tick rates counted over 256 cycles
`timescale 1ns/1ns
module tb_pwm_ctrl;
    logic clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, clk_b_tick;
    logic wait_mode = 1'h0, freeze_mode = 1'h0, pready, pslverr, er, prescaler_run, clk_a_tick;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] channel_enable_bits = 8'h00, center_mode_bits, effective_enable;
    logic [7:0] high_byte_channel, ctrl_owner_odd;
    logic [3:0] pair_bits;
    int err_total = 0, tests_run = 0;
    pwm_ctrl dut_u (.*);
    initial forever #25 clk = ~clk;
    task chk(input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        {er, rd} = {pslverr, prdata};
        {psel, penable} <= 2'h0;
        @(posedge clk);
    endtask
    task wr_rd(input logic [11:0] a, input logic [31:0] d, e);
        apb(1'h1, a, d);
        apb(1'h0, a, 32'h0);
        chk(rd, e);
    endtask
    task give_verdict;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task t_regs;
        apb(1'h0, 12'h014, 32'h0);
        chk(rd, 32'h0);
        wr_rd(12'h00C, 32'hFF, 32'h77);
        wr_rd(12'h010, 32'hA5, 32'hA5);
        wr_rd(12'h014, 32'hFF, 32'hFC);
        wr_rd(12'h018, 32'hFF, 32'h0);
        chk(er, 1'h1);
    endtask
    task automatic t_pair;
        for (int k = 0; k < 4; k++) begin
            logic [7:0] m = 8'h01 << (2 * k);
            channel_enable_bits <= 8'h00;
            @(posedge clk);
            apb(1'h1, 12'h014, 32'h10 << k);
            channel_enable_bits <= 8'hFF;
            repeat (3) @(posedge clk);
            chk(effective_enable, 8'(~m));
            chk(high_byte_channel, m);
            chk(ctrl_owner_odd, 8'(m << 1));
        end
    endtask
    task automatic t_rate;
        for (int n = 0; n < 8; n++) begin
            int ca = 0, cb = 0;
            apb(1'h1, 12'h00C, {25'h0, 3'(7 - n), 1'h0, n[2:0]});
            repeat (256) begin
                @(posedge clk);
                ca += clk_a_tick;
                cb += clk_b_tick;
            end
            chk(ca, 256 >> n);
            chk(cb, 256 >> (7 - n));
        end
    endtask
    task t_modes;
        wr_rd(12'h014, 32'h0C, 32'h0C);
        wait_mode <= 1'h1;
        repeat (3) @(posedge clk);
        chk(prescaler_run, 1'h0);
        wait_mode <= 1'h0;
        freeze_mode <= 1'h1;
        repeat (3) @(posedge clk);
        chk(prescaler_run, 1'h0);
        wait_mode <= 1'h1;
        wr_rd(12'h014, 32'h0, 32'h0);
        repeat (2) @(posedge clk);
        chk(prescaler_run, 1'h1);
        freeze_mode <= 1'h0;
        wait_mode <= 1'h0;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        resetn <= 1'h1;
        repeat (4) @(posedge clk);
        t_regs;
        t_pair;
        t_rate;
        t_modes;
        give_verdict;
    end
    initial #1000000 begin
        err_total++;
        give_verdict;
    end
endmodule
